// file: rtl/cic_pkg.sv
// Constants, types and state record of the CPU interrupt control block
package cic_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [11:0] ADDR_VECTOR_BASE = 12'h000;
  localparam logic [11:0] ADDR_MODE = 12'h004;
  localparam logic [11:0] ADDR_STATUS = 12'h008;
  localparam logic [11:0] ADDR_OPS = 12'h00C;

  // Operation bits of the OPS register (write-only pulses)
  localparam int OP_MASK_BIT = 0;
  localparam int OP_UNMASK_BIT = 1;
  localparam int OP_NMI_RET_BIT = 2;
  localparam int OP_LD_VBASE_BIT = 3;
  localparam int OP_LD_REFRESH_BIT = 4;

  // Status bit positions
  localparam int ST_IRQ_ENABLE_PRIMARY_BIT = 0;
  localparam int ST_IRQ_ENABLE_SHADOW_BIT = 1;
  localparam int ST_NMI_PEND_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int ST_GRANT_BIT = 4;
  localparam int ST_PARITY_BIT = 5;

  // ----------------------------------------------------------------
  // Reset values, vectors, mode codes, cycle counts
  // ----------------------------------------------------------------
  localparam logic [7:0] VECTOR_BASE_RESET = 8'h00;
  localparam logic [1:0] MODE_RESET = 2'h0;
  localparam logic [1:0] MODE_0 = 2'h0;
  localparam logic [1:0] MODE_UNUSED = 2'h1;
  localparam logic [1:0] MODE_1 = 2'h2;
  localparam logic [1:0] MODE_2 = 2'h3;
  localparam logic [15:0] NMI_RESTART = 16'h0066;
  localparam logic [15:0] MODE1_RESTART = 16'h0038;
  localparam logic [7:0] CALL_OPCODE = 8'hCD;
  localparam logic [2:0] ACK_T_STATES = 3'h2;
  localparam logic [2:0] ACK_WAIT_STATES = 3'h2;
  localparam logic [2:0] ACK_CYCLES = 3'(ACK_T_STATES + ACK_WAIT_STATES);
  localparam logic [2:0] MEM_READ_CYCLES = 3'h3;

  typedef enum logic [2:0] {
    CIC_IDLE, CIC_ACK, CIC_RD_LO, CIC_RD_HI, CIC_PUSH, CIC_JUMP
  } cic_phase_t;

  // Bus cycle strobes toward the system
  typedef struct packed {
    logic opcode_fetch_cycle;
    logic io_request_strobe;
    logic memory_request_strobe;
    logic [15:0] addr;
  } cic_cycle_t;

  typedef struct packed {
    logic nmi_s1, nmi_s2, nmi_prev;
    logic int_s1, int_s2;
    logic brq_s1, brq_s2;
    logic [7:0] dat_s1, dat_s2;
    logic nmi_pend;
    logic irq_enable_primary, irq_enable_shadow;
    logic [1:0] irq_mode_pair;
    logic [7:0] vbase;
    logic parity;
    logic granted;
    cic_phase_t phase;
    logic [2:0] cnt;
    logic [7:0] byte_lo;
    logic [15:0] ptr;
    logic [15:0] target;
    cic_cycle_t cyc;
    logic push_valid;
    logic [15:0] push_data;
    logic jump_valid;
    logic [15:0] jump_addr;
    logic [31:0] prdata;
  } cic_state_t;

endpackage

// file: rtl/cic_top.sv
// Interrupt acceptance, acknowledge sequencing and enable flip-flops
// ----------------------------------------------------------------
// Contract
// - NMI accepted regardless of enable flip-flops
// - NMI restarts at 0066H when bus free
// - INT acknowledge fetch uses IO strobe
// - Acknowledge fetch gets two extra wait states
// - Mode 0 call: one ack, two reads
// - Mode 1 restarts at 0038H
// - Mode 2 pointer is base:vector, table read
// - Pending requests are queued, not dropped
// - Reset/mask clear, unmask sets both flip-flops
// - Accumulator loads copy shadow to parity
// - NMI accept copies primary to shadow, clears
// - NMI return restores primary from shadow
// - Interrupts evaluated only at instruction end
// - Bus request evaluated at machine cycle end
// - Interrupts ignored while bus is granted
// - Priority: bus request, NMI, INT
// - Inputs sampled on last instruction clock
// - Mode flip-flops coded 00, 10, 11
// ----------------------------------------------------------------
`timescale 1ns/10ps
`default_nettype none

module cic_top
  import cic_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Interrupt and bus request pins
  input wire logic nmi_n,
  input wire logic int_n,
  input wire logic bus_request_pin_n,
  input wire logic [7:0] data_in,
  // Core timing and program counter
  input wire logic instr_last_clk,
  input wire logic mcycle_end,
  input wire logic [15:0] pc_in,
  // Bus cycle and core requests
  output logic opcode_fetch_cycle,
  output logic io_request_strobe,
  output logic memory_request_strobe,
  output logic [15:0] addr_out,
  output logic bus_grant,
  output logic push_valid,
  output logic [15:0] push_data,
  output logic jump_valid,
  output logic [15:0] jump_addr,
  output logic parity_flag
);

  function automatic logic is_addr(input logic [11:0] a, input logic [11:0] k);
    return a == k;
  endfunction

  cic_state_t s, next_s;
  logic setup_ph, wr_acc, mapped, nmi_edge, int_live, bus_req, busy, take_nmi, take_int;
  logic [4:0] ops;

  assign bus_req = s.brq_s2;
  assign busy = (s.phase != CIC_IDLE);
  assign setup_ph = psel && !penable;
  assign wr_acc = psel && penable && pwrite;
  assign mapped = is_addr(paddr, ADDR_VECTOR_BASE) || is_addr(paddr, ADDR_MODE)
                  || is_addr(paddr, ADDR_STATUS) || is_addr(paddr, ADDR_OPS);
  assign ops = (wr_acc && is_addr(paddr, ADDR_OPS)) ? pwdata[4:0] : 5'h00;
  // Synced copies are active high: the pin's falling edge is a rise here
  assign nmi_edge = !s.nmi_prev && s.nmi_s2 && !s.granted;
  assign int_live = s.int_s2 && !s.granted;
  // Bus request blocks both interrupts in its cycle; sampling only at instruction end
  assign take_nmi = !busy && !s.granted && instr_last_clk
                    && !(mcycle_end && bus_req)
                    && (s.nmi_pend || nmi_edge);
  assign take_int = !busy && !s.granted && instr_last_clk && !take_nmi
                    && !(mcycle_end && bus_req)
                    && int_live && s.irq_enable_primary;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.nmi_s1 = !nmi_n;
    next_s.nmi_s2 = s.nmi_s1;
    next_s.nmi_prev = s.nmi_s2;
    next_s.int_s1 = !int_n;
    next_s.int_s2 = s.int_s1;
    next_s.brq_s1 = !bus_request_pin_n;
    next_s.brq_s2 = s.brq_s1;
    next_s.dat_s1 = data_in;
    next_s.dat_s2 = s.dat_s1;
    next_s.push_valid = 1'b0;
    next_s.jump_valid = 1'b0;

    // Register writes
    if (wr_acc && is_addr(paddr, ADDR_VECTOR_BASE)) begin
      next_s.vbase = pwdata[7:0];
    end
    if (wr_acc && is_addr(paddr, ADDR_MODE)) begin
      next_s.irq_mode_pair = pwdata[1:0];
    end
    if (ops[OP_MASK_BIT]) begin
      next_s.irq_enable_primary = 1'b0;
      next_s.irq_enable_shadow = 1'b0;
    end else if (ops[OP_UNMASK_BIT]) begin
      next_s.irq_enable_primary = 1'b1;
      next_s.irq_enable_shadow = 1'b1;
    end else if (ops[OP_NMI_RET_BIT]) begin
      next_s.irq_enable_primary = s.irq_enable_shadow;
    end
    if (ops[OP_LD_VBASE_BIT] || ops[OP_LD_REFRESH_BIT]) begin
      next_s.parity = s.irq_enable_shadow;
    end

    // Read data is latched in the setup phase, valid through the access phase
    if (setup_ph) begin
      next_s.prdata = 32'h0000_0000;
      if (is_addr(paddr, ADDR_VECTOR_BASE)) begin
        next_s.prdata[7:0] = s.vbase;
      end else if (is_addr(paddr, ADDR_MODE)) begin
        next_s.prdata[1:0] = s.irq_mode_pair;
      end else if (is_addr(paddr, ADDR_STATUS)) begin
        next_s.prdata[ST_IRQ_ENABLE_PRIMARY_BIT] = s.irq_enable_primary;
        next_s.prdata[ST_IRQ_ENABLE_SHADOW_BIT] = s.irq_enable_shadow;
        next_s.prdata[ST_NMI_PEND_BIT] = s.nmi_pend;
        next_s.prdata[ST_BUSY_BIT] = busy;
        next_s.prdata[ST_GRANT_BIT] = s.granted;
        next_s.prdata[ST_PARITY_BIT] = s.parity;
      end
    end

    // Bus grant: taken only at a machine cycle end, between sequences
    if (!busy && mcycle_end && bus_req) begin
      next_s.granted = 1'b1;
    end else if (!bus_req) begin
      next_s.granted = 1'b0;
    end

    // NMI edge kept until served; a new edge wins over the clear
    if (take_nmi) begin
      next_s.nmi_pend = 1'b0;
    end
    if (nmi_edge && !(take_nmi && !s.nmi_pend)) begin
      next_s.nmi_pend = 1'b1;
    end

    case (s.phase)
      CIC_IDLE: begin
        if (take_nmi) begin
          next_s.irq_enable_shadow = s.irq_enable_primary;
          next_s.irq_enable_primary = 1'b0;
          next_s.target = NMI_RESTART;
          next_s.phase = CIC_PUSH;
        end else if (take_int) begin
          next_s.irq_enable_primary = 1'b0;
          next_s.irq_enable_shadow = 1'b0;
          next_s.cyc.opcode_fetch_cycle = 1'b1;
          next_s.cyc.io_request_strobe = 1'b1;
          next_s.cyc.memory_request_strobe = 1'b0;
          next_s.cyc.addr = pc_in;
          next_s.cnt = 3'h1;
          next_s.phase = CIC_ACK;
        end
      end
      CIC_ACK: begin
        // Two T states plus two automatic waits before the byte is taken
        if (s.cnt < ACK_CYCLES) begin
          next_s.cnt = 3'(s.cnt + 3'h1);
        end else begin
          next_s.cyc.opcode_fetch_cycle = 1'b0;
          next_s.cyc.io_request_strobe = 1'b0;
          next_s.cnt = 3'h1;
          case (s.irq_mode_pair)
            MODE_1: begin
              next_s.target = MODE1_RESTART;
              next_s.phase = CIC_PUSH;
            end
            MODE_2: begin
              // Low bit forced to zero keeps the table word aligned
              next_s.ptr = {s.vbase, s.dat_s2[7:1], 1'b0};
              next_s.cyc.memory_request_strobe = 1'b1;
              next_s.cyc.addr = {s.vbase, s.dat_s2[7:1], 1'b0};
              next_s.phase = CIC_RD_LO;
            end
            default: begin
              // Mode 0 and the unused code: the byte is an instruction
              if (s.dat_s2 == CALL_OPCODE) begin
                next_s.ptr = pc_in;
                next_s.cyc.memory_request_strobe = 1'b1;
                next_s.cyc.addr = pc_in;
                next_s.phase = CIC_RD_LO;
              end else begin
                next_s.target = {10'h000, s.dat_s2[5:3], 3'h0};
                next_s.phase = CIC_PUSH;
              end
            end
          endcase
        end
      end
      CIC_RD_LO: begin
        if (s.cnt < MEM_READ_CYCLES) begin
          next_s.cnt = 3'(s.cnt + 3'h1);
        end else begin
          next_s.byte_lo = s.dat_s2;
          next_s.cnt = 3'h1;
          next_s.cyc.addr = 16'(s.ptr + 16'h0001);
          next_s.phase = CIC_RD_HI;
        end
      end
      CIC_RD_HI: begin
        if (s.cnt < MEM_READ_CYCLES) begin
          next_s.cnt = 3'(s.cnt + 3'h1);
        end else begin
          next_s.target = {s.dat_s2, s.byte_lo};
          next_s.cyc.memory_request_strobe = 1'b0;
          next_s.phase = CIC_PUSH;
        end
      end
      CIC_PUSH: begin
        next_s.push_valid = 1'b1;
        next_s.push_data = pc_in;
        next_s.phase = CIC_JUMP;
      end
      CIC_JUMP: begin
        next_s.jump_valid = 1'b1;
        next_s.jump_addr = s.target;
        next_s.phase = CIC_IDLE;
      end
      default: begin
        next_s.phase = CIC_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.irq_mode_pair <= MODE_RESET;
      s.vbase <= VECTOR_BASE_RESET;
      s.irq_enable_primary <= 1'b0;
      s.irq_enable_shadow <= 1'b0;
      s.phase <= CIC_IDLE;
    end else begin
      s <= next_s;
    end
  end

  assign prdata = s.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign opcode_fetch_cycle = s.cyc.opcode_fetch_cycle;
  assign io_request_strobe = s.cyc.io_request_strobe;
  assign memory_request_strobe = s.cyc.memory_request_strobe;
  assign addr_out = s.cyc.addr;
  assign bus_grant = s.granted;
  assign push_valid = s.push_valid;
  assign push_data = s.push_data;
  assign jump_valid = s.jump_valid;
  assign jump_addr = s.jump_addr;
  assign parity_flag = s.parity;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_nmi_always_taken: assert property ((!busy && !s.granted && instr_last_clk && !mcycle_end
      && s.nmi_pend) |-> take_nmi) else $error("pending nmi not taken");
  a_nmi_restart_addr: assert property (take_nmi |-> ##3 (jump_valid && jump_addr == 16'h0066))
    else $error("nmi restart address wrong");
  a_ack_io_strobe: assert property (opcode_fetch_cycle |-> (io_request_strobe
      && !memory_request_strobe)) else $error("ack fetch strobes wrong");
  a_ack_four_cycles: assert property ($rose(opcode_fetch_cycle) |-> opcode_fetch_cycle[*4]
      ##1 !opcode_fetch_cycle) else $error("ack fetch length wrong");
  a_mode1_restart: assert property ((s.phase == CIC_ACK && s.cnt == ACK_CYCLES
      && s.irq_mode_pair == MODE_1) |-> ##3 (jump_valid && jump_addr == 16'h0038))
    else $error("mode 1 restart address wrong");
  a_vector_aligned: assert property ((s.phase == CIC_RD_LO && s.irq_mode_pair == MODE_2)
      |-> !addr_out[0] && addr_out[15:8] == s.vbase) else $error("vector pointer wrong");
  a_nmi_iff_copy: assert property (take_nmi |=> (!s.irq_enable_primary
      && s.irq_enable_shadow == $past(s.irq_enable_primary))) else $error("nmi iff copy");
  a_int_iff_clear: assert property (take_int |=> (!s.irq_enable_primary
      && !s.irq_enable_shadow)) else $error("int accept left iff set");
  a_no_int_granted: assert property (s.granted |-> (!take_int && !take_nmi))
    else $error("interrupt taken while bus granted");
  a_push_before_jump: assert property (push_valid |=> jump_valid)
    else $error("jump did not follow push");
  a_parity_copy: assert property ((ops[OP_LD_VBASE_BIT] && s.phase == CIC_IDLE && !take_nmi
      && !take_int) |=> (parity_flag == $past(s.irq_enable_shadow)))
    else $error("parity copy wrong");

  c_nmi_taken: cover property (take_nmi ##3 jump_valid);
  c_mode2_ack: cover property (take_int && s.irq_mode_pair == MODE_2);
  c_mode0_call: cover property (s.phase == CIC_RD_HI && s.irq_mode_pair == MODE_0);
  c_bus_grant: cover property ($rose(bus_grant));

endmodule // cic_top

`default_nettype wire

// file: test/cic_periph_model.sv
// Daisy-chained peripheral pair and memory answering the interrupt block
`timescale 1ns/10ps
`default_nettype none

module cic_periph_model
  import cic_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Bench control
  input wire logic [1:0] req,
  input wire logic [1:0] done,
  input wire logic [7:0] vec0,
  input wire logic [7:0] vec1,
  // Block side
  input wire logic opcode_fetch_cycle,
  input wire logic io_request_strobe,
  input wire logic memory_request_strobe,
  input wire logic [15:0] addr_out,
  output logic int_n,
  output logic [7:0] data_in
);
  logic [1:0] pend, svc, win, chain_enable_in, chain_enable_out;
  logic ack, ack_q;
  logic [7:0] last;

  assign ack = opcode_fetch_cycle & io_request_strobe;
  assign chain_enable_in = {chain_enable_out[0], 1'b1};
  assign chain_enable_out = chain_enable_in & ~svc;
  assign win = (pend[0] & chain_enable_in[0]) ? 2'b01 : {pend[1] & chain_enable_in[1], 1'b0};
  assign int_n = ~|(pend & chain_enable_in);

  always_comb begin
    if (ack)
      data_in = (svc[0] | win[0]) ? vec0 : vec1;
    else if (memory_request_strobe)
      data_in = addr_out[7:0] ^ addr_out[15:8] ^ 8'hA5;
    else
      data_in = ~last; // Released bus toggles so no stale byte is read
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= 2'h0;
      svc <= 2'h0;
      ack_q <= 1'b0;
      last <= 8'h00;
    end else begin
      ack_q <= ack;
      pend <= (pend | req) & ~((ack & !ack_q) ? win : 2'h0);
      svc <= (svc | ((ack & !ack_q) ? win : 2'h0)) & ~done;
      last <= data_in;
    end
  end
endmodule // cic_periph_model

`default_nettype wire

// file: test/cic_top_tb_top.sv
// Self-checking bench of the interrupt control block
`timescale 1ns/10ps
`default_nettype none

`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_fail++; \
  $display("[ERR] %0t got %h exp %h", $time, a, e); end end

module cic_top_tb_top;
  import cic_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, nmi_n = 1;
  logic bus_request_pin_n = 1, instr_last_clk = 0, mcycle_end = 0, mem_seen = 0;
  logic pready, pslverr, opcode_fetch_cycle, io_request_strobe, memory_request_strobe;
  logic bus_grant, push_valid, jump_valid, parity_flag, int_n;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, e;
  logic [32:0] e2;
  logic [7:0] data_in, vec0 = 0, vec1 = 0, lf = 8'h1C, vb;
  logic [15:0] pc_in = 0, pc, addr_out, jump_addr, push_data, last_push;
  logic [1:0] req = 0, done = 0, cyc = 0;
  logic [2:0] ackn = 0;
  logic [31:0] jq[$];
  logic [32:0] rq[$];
  int n_fail = 0, check_count = 0, tmo = 0;

  always #2.5 pclk = ~pclk;

  cic_top i_cic_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nmi_n(nmi_n), .int_n(int_n), .bus_request_pin_n(bus_request_pin_n),
    .data_in(data_in), .instr_last_clk(instr_last_clk), .mcycle_end(mcycle_end),
    .pc_in(pc_in), .opcode_fetch_cycle(opcode_fetch_cycle),
    .io_request_strobe(io_request_strobe), .memory_request_strobe(memory_request_strobe),
    .addr_out(addr_out), .bus_grant(bus_grant), .push_valid(push_valid),
    .push_data(push_data), .jump_valid(jump_valid), .jump_addr(jump_addr),
    .parity_flag(parity_flag));

  cic_periph_model i_cic_periph_model (.pclk(pclk), .presetn(presetn), .req(req),
    .done(done), .vec0(vec0), .vec1(vec1), .opcode_fetch_cycle(opcode_fetch_cycle),
    .io_request_strobe(io_request_strobe), .memory_request_strobe(memory_request_strobe),
    .addr_out(addr_out), .int_n(int_n), .data_in(data_in));

  function logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  function logic [7:0] mem(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'hA5;
  endfunction

  function logic [15:0] tbl(input logic [15:0] p);
    return {mem(p + 16'h1), mem(p)};
  endfunction

  // ----------------------------------------------------------------
  // Core timing: instruction ends every fourth clock
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    cyc <= cyc + 2'h1;
    instr_last_clk <= (cyc == 2'h2);
    mcycle_end <= cyc[0];
  end

  // ----------------------------------------------------------------
  // Monitor: oldest note against each result
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (presetn) begin
      if (push_valid) last_push <= push_data;
      if (jump_valid && jq.size() == 0) `CHK(jump_valid, 1'b0)
      if (jump_valid && jq.size() != 0) begin
        e = jq.pop_front();
        `CHK(last_push, e[31:16])
        `CHK(jump_addr, e[15:0])
      end
      if (psel & penable & pready & !pwrite) begin
        e2 = rq.pop_front();
        `CHK({pslverr, prdata}, e2)
      end
      if (opcode_fetch_cycle & io_request_strobe) begin
        ackn <= ackn + 3'h1;
        mem_seen <= mem_seen | memory_request_strobe;
      end else if (ackn != 3'h0) begin
        `CHK({mem_seen, ackn}, {1'b0, ACK_CYCLES})
        ackn <= 3'h0;
        mem_seen <= 1'b0;
      end
    end
  end

  task tally_and_finish();
    if (n_fail == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  always @(posedge pclk) begin
    tmo <= tmo + 1;
    if (tmo == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [32:0] x);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    if (!w) rq.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, {1'b0, x});
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0);
  endtask

  task op(input int b);
    wr(ADDR_OPS, 32'h1 << b);
  endtask

  task newpc();
    lf = lfsr(lf);
    pc = {lf, lfsr(lf)};
    lf = lfsr(lf);
    pc_in <= pc;
    @(posedge pclk);
  endtask

  task nmi();
    nmi_n <= 1'b0;
    repeat (6) @(posedge pclk);
    nmi_n <= 1'b1;
    req <= 2'h0;
  endtask

  task drain(input logic [1:0] dn);
    int i;
    for (i = 0; i < 300 && jq.size() != 0; i++) @(posedge pclk);
    `CHK(jq.size(), 0)
    repeat (20) @(posedge pclk);
    done <= dn;
    @(posedge pclk);
    done <= 2'h0;
  endtask

  initial begin
    int k;
    logic [1:0] m;
    logic [15:0] t;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_VECTOR_BASE, {24'h0, VECTOR_BASE_RESET});
    rd(ADDR_MODE, {30'h0, MODE_RESET});
    rd(ADDR_STATUS, 32'h0);
    apb(1'b0, 12'h010, 32'h0, {1'b1, 32'h0});
    lf = lfsr(lf);
    vb = lf;
    wr(ADDR_VECTOR_BASE, {24'h0, vb});
    rd(ADDR_VECTOR_BASE, {24'h0, vb});
    op(OP_UNMASK_BIT);
    rd(ADDR_STATUS, 32'h03);
    op(OP_LD_VBASE_BIT);
    `CHK(parity_flag, 1'b1)
    rd(ADDR_STATUS, 32'h23);
    op(OP_MASK_BIT);
    rd(ADDR_STATUS, 32'h20);
    op(OP_LD_REFRESH_BIT);
    `CHK(parity_flag, 1'b0)
    rd(ADDR_STATUS, 32'h00);
    // Non-maskable taken with enables clear, then set
    newpc();
    jq.push_back({pc, NMI_RESTART});
    nmi();
    drain(2'h0);
    op(OP_UNMASK_BIT);
    jq.push_back({pc, NMI_RESTART});
    nmi();
    drain(2'h0);
    rd(ADDR_STATUS, 32'h02);
    op(OP_NMI_RET_BIT);
    rd(ADDR_STATUS, 32'h03);
    // Each response mode in turn
    for (k = 0; k < 4; k++) begin
      newpc();
      case (k)
        0: begin m = MODE_1; t = MODE1_RESTART; end
        1: begin m = MODE_2; vec0 <= lf & 8'hFE; t = tbl({vb, lf & 8'hFE}); end
        2: begin m = MODE_0; vec0 <= {2'b11, lf[2:0], 3'b111}; t = {10'h0, lf[2:0], 3'h0}; end
        default: begin m = MODE_0; vec0 <= CALL_OPCODE; t = tbl(pc); end
      endcase
      wr(ADDR_MODE, {30'h0, m});
      rd(ADDR_MODE, {30'h0, m});
      op(OP_UNMASK_BIT);
      jq.push_back({pc, t});
      req <= 2'b01;
      @(posedge pclk);
      req <= 2'b00;
      drain(2'h3);
      rd(ADDR_STATUS, 32'h0);
    end
    // Requests held while masked, then served by chain position
    wr(ADDR_MODE, {30'h0, MODE_2});
    vec0 <= 8'h10;
    vec1 <= 8'h20;
    req <= 2'b11;
    @(posedge pclk);
    req <= 2'b00;
    repeat (40) @(posedge pclk);
    jq.push_back({pc, tbl({vb, 8'h10})});
    op(OP_UNMASK_BIT);
    drain(2'h0);
    op(OP_UNMASK_BIT);
    repeat (40) @(posedge pclk);
    jq.push_back({pc, tbl({vb, 8'h20})});
    // Upper device finishes service; only now may the lower one be heard
    done <= 2'h1;
    @(posedge pclk);
    done <= 2'h0;
    drain(2'h3);
    // Coincident non-maskable and maskable requests
    op(OP_UNMASK_BIT);
    vec0 <= 8'h30;
    jq.push_back({pc, NMI_RESTART});
    jq.push_back({pc, tbl({vb, 8'h30})});
    req <= 2'b01;
    nmi();
    repeat (40) @(posedge pclk);
    op(OP_NMI_RET_BIT);
    drain(2'h3);
    // Bus handed away: NMI pin ignored
    bus_request_pin_n <= 1'b0;
    repeat (12) @(posedge pclk);
    `CHK(bus_grant, 1'b1)
    nmi();
    repeat (10) @(posedge pclk);
    bus_request_pin_n <= 1'b1;
    repeat (12) @(posedge pclk);
    `CHK(bus_grant, 1'b0)
    repeat (40) @(posedge pclk);
    rd(ADDR_STATUS, 32'h0);
    // Reset in mid-run must clear enables set by software
    op(OP_UNMASK_BIT);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_STATUS, 32'h0);
    rd(ADDR_VECTOR_BASE, {24'h0, VECTOR_BASE_RESET});
    tally_and_finish();
  end
endmodule // cic_top_tb_top

`default_nettype wire
